// file: dsc_pkg.sv
package dsc_pkg;
   // -------------------------------------------------------------
   // widths and types
   // -------------------------------------------------------------
   typedef logic [31:0] dsc_word_t;
   typedef logic [15:0] dsc_instr_t;
   typedef logic [3:0] dsc_reg_idx_t;
   localparam int GPR_N = 16;

   // -------------------------------------------------------------
   // opcode groups, low-nibble or low-byte selectors, high-byte and full-word opcodes
   // -------------------------------------------------------------
   localparam logic [3:0] OPG_ZERO = 4'h0;
   localparam logic [3:0] OPG_FOUR = 4'h4;
   localparam logic [3:0] LO_STS = 4'hA;
   localparam logic [3:0] LO_STS_PD = 4'h2;
   localparam logic [3:0] LO_STC = 4'h2;
   localparam logic [3:0] LO_STC_PD = 4'h3;
   localparam logic [3:0] LO_LDC = 4'hE;
   localparam logic [3:0] LO_LDC_PI = 4'h7;
   localparam logic [7:0] LO_SET_REPEAT_COUNT_REG = 8'h14;
   localparam logic [7:0] OP_SET_REPEAT_COUNT_IMM = 8'h82;
   localparam logic [7:0] OP_LOAD_REPEAT_START_PCREL = 8'h8C;
   localparam logic [7:0] OP_LOAD_REPEAT_END_PCREL = 8'h8E;
   localparam logic [7:0] OP_TRAP = 8'hC3;
   localparam logic [15:0] OP_SLEEP = 16'h001B;

   // source nibbles of system and dsp registers
   localparam logic [3:0] SRC_MULTIPLY_ACC_HIGH = 4'h0;
   localparam logic [3:0] SRC_MULTIPLY_ACC_LOW = 4'h1;
   localparam logic [3:0] SRC_PR = 4'h2;
   localparam logic [3:0] SRC_DSR = 4'h6;
   localparam logic [3:0] SRC_A0 = 4'h7;
   localparam logic [3:0] SRC_X0 = 4'h8;
   localparam logic [3:0] SRC_X1 = 4'h9;
   localparam logic [3:0] SRC_Y0 = 4'hA;
   localparam logic [3:0] SRC_Y1 = 4'hB;
   // control register nibbles
   localparam logic [3:0] CTL_SR = 4'h0;
   localparam logic [3:0] CTL_GBR = 4'h1;
   localparam logic [3:0] CTL_VBR = 4'h2;
   localparam logic [3:0] CTL_MOD = 4'h5;
   localparam logic [3:0] CTL_RS = 4'h6;
   localparam logic [3:0] CTL_RE = 4'h7;

   // -------------------------------------------------------------
   // address arithmetic and status fields
   // -------------------------------------------------------------
   localparam dsc_reg_idx_t STACK_REG = 4'hF;
   localparam dsc_word_t PREDEC_STEP = 32'h4;
   localparam dsc_word_t POSTINC_STEP = 32'h4;
   localparam dsc_word_t PC_STEP = 32'h2;
   localparam int RC_HI = 27;
   localparam int RC_LO = 16;
   localparam int RC_IMM_HI = 23;
   localparam int RC_UP_LO = 24;
   localparam int RF_HI = 3;
   localparam int RF_LO = 2;
   localparam logic [1:0] RF_ONE = 2'h0;
   localparam logic [1:0] RF_TWO = 2'h1;
   localparam logic [1:0] RF_THREE = 2'h3;
   localparam logic [1:0] RF_MORE = 2'h2;
   localparam dsc_word_t SPAN_ONE = 32'h0;
   localparam dsc_word_t SPAN_TWO = 32'h2;
   localparam dsc_word_t SPAN_THREE = 32'h4;
   localparam dsc_word_t STATUS_RST = 32'h0;
   localparam dsc_word_t WORD_RST = 32'h0;

   // -------------------------------------------------------------
   // cycle counts
   // -------------------------------------------------------------
   localparam logic [3:0] TRAP_CYC = 4'h8;
   localparam logic [3:0] SLEEP_CYC = 4'h3;
   localparam logic [3:0] CNT_MAX = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE, ST_STALL, ST_EXEC, ST_MEM, ST_TRAP_END, ST_SLEEP
   } dsc_state_t;
endpackage

// file: dsc_gpr_mem.sv
`timescale 1ns/100ps
module dsc_gpr_mem (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input dsc_pkg::dsc_reg_idx_t rd_addr,
   output dsc_pkg::dsc_word_t rd_data,
   input wire logic wr_en,
   input dsc_pkg::dsc_reg_idx_t wr_addr,
   input dsc_pkg::dsc_word_t wr_data
);
   import dsc_pkg::*;

   dsc_word_t mem_ff [GPR_N];
   dsc_word_t rd_data_ff;

   // array has no reset; software owns general register contents
   always_ff @(posedge sys_clk) begin
      if (clk_en && wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_data_ff <= WORD_RST;
      end else if (clk_en) begin
         rd_data_ff <= mem_ff[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;
endmodule

// file: dsc_sys_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - store system register into general register
// - predecrement by four, then store to memory
// - trap saves pc and status, vectors
// - fetch contention adds stall cycles
// - load-use on same register stalls next
// - branch target at 4n+2 adds cycles
// - sleep cycles counted before sleep entry
// - twelve-bit repeat count in status 27:16
// - repeat flags in status bits 3:2
// - immediate count goes to status 23:16
// - immediate form clears status 27:24
// - register form copies bits 11:0
// - flags encode one, two, three, more
// - flags derived from repeat end minus start
// - repeat start, end and modulo registers
// - control load/store reach those registers
// - pc-relative loads set repeat start/end
// - pc-relative address is disp*2 plus pc
module dsc_sys_ctrl (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic instr_valid,
   input dsc_pkg::dsc_instr_t instr_word,
   input dsc_pkg::dsc_word_t instr_pc,
   output logic instr_ready,
   output logic instr_done,
   input wire logic ext_load_valid,
   input dsc_pkg::dsc_reg_idx_t ext_load_dest,
   input wire logic branch_taken,
   input dsc_pkg::dsc_word_t branch_target,
   input wire logic fetch_busy,
   output logic mem_req,
   output logic mem_we,
   output dsc_pkg::dsc_word_t mem_addr,
   output dsc_pkg::dsc_word_t mem_wdata,
   input wire logic mem_ack,
   input dsc_pkg::dsc_word_t mem_rdata,
   output logic pc_load,
   output dsc_pkg::dsc_word_t pc_load_val,
   output logic sleep_enter,
   input wire logic wake_req,
   output dsc_pkg::dsc_word_t status_word,
   output dsc_pkg::dsc_word_t repeat_start_addr,
   output dsc_pkg::dsc_word_t repeat_end_addr,
   output dsc_pkg::dsc_word_t modulo_addr_reg,
   input dsc_pkg::dsc_word_t multiply_acc_high,
   input dsc_pkg::dsc_word_t multiply_acc_low,
   input dsc_pkg::dsc_word_t procedure_return,
   input dsc_pkg::dsc_word_t dsp_status,
   input dsc_pkg::dsc_word_t accumulator_zero,
   input dsc_pkg::dsc_word_t x_input_zero,
   input dsc_pkg::dsc_word_t x_input_one,
   input dsc_pkg::dsc_word_t y_input_zero,
   input dsc_pkg::dsc_word_t y_input_one,
   input dsc_pkg::dsc_word_t global_base,
   input dsc_pkg::dsc_word_t vector_base
);
   import dsc_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   dsc_state_t state_ff, nxt_state;
   dsc_instr_t ir_ff, nxt_ir;
   dsc_word_t pc_ff, nxt_pc, sp_ff, nxt_sp;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [1:0] trap_ph_ff, nxt_trap_ph;
   logic misalign_ff, nxt_misalign;
   logic ready_ff, nxt_ready, done_ff, nxt_done;
   logic mreq_ff, nxt_mreq, mwe_ff, nxt_mwe;
   dsc_word_t maddr_ff, nxt_maddr, mwdata_ff, nxt_mwdata;
   logic pcl_ff, nxt_pcl, sleep_ff, nxt_sleep;
   dsc_word_t pclv_ff, nxt_pclv;
   dsc_word_t status_ff, nxt_status, rs_ff, nxt_rs, re_ff, nxt_re, mod_ff, nxt_mod;

   logic gpr_we, ctl_we, finish, accept, stall_need;
   dsc_reg_idx_t gpr_raddr, gpr_waddr;
   dsc_word_t gpr_rdata, gpr_wdata, ctl_val, span;
   logic [3:0] ctl_sel;
   logic [32:0] sys_sel, ctl_rd;
   logic is_sts, is_stc, is_sts_pd, is_stc_pd, is_ldc, is_ldc_pi;
   logic is_set_repeat_count_r, is_set_repeat_count_i, is_load_repeat_start_pcrel, is_load_repeat_end_pcrel, is_trap, is_sleep;

   // -------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------
   function automatic logic [32:0] sys_src(input logic [3:0] nib);
      case (nib)
         SRC_MULTIPLY_ACC_HIGH: sys_src = {1'b1, multiply_acc_high};
         SRC_MULTIPLY_ACC_LOW: sys_src = {1'b1, multiply_acc_low};
         SRC_PR: sys_src = {1'b1, procedure_return};
         SRC_DSR: sys_src = {1'b1, dsp_status};
         SRC_A0: sys_src = {1'b1, accumulator_zero};
         SRC_X0: sys_src = {1'b1, x_input_zero};
         SRC_X1: sys_src = {1'b1, x_input_one};
         SRC_Y0: sys_src = {1'b1, y_input_zero};
         SRC_Y1: sys_src = {1'b1, y_input_one};
         default: sys_src = {1'b0, WORD_RST};
      endcase
   endfunction

   function automatic logic [32:0] ctl_src(input logic [3:0] nib);
      case (nib)
         CTL_SR: ctl_src = {1'b1, status_ff};
         CTL_GBR: ctl_src = {1'b1, global_base};
         CTL_VBR: ctl_src = {1'b1, vector_base};
         CTL_MOD: ctl_src = {1'b1, mod_ff};
         CTL_RS: ctl_src = {1'b1, rs_ff};
         CTL_RE: ctl_src = {1'b1, re_ff};
         default: ctl_src = {1'b0, WORD_RST};
      endcase
   endfunction

   // only registers held here are loadable; base registers live elsewhere
   function automatic logic ctl_loadable(input logic [3:0] nib);
      ctl_loadable = (nib == CTL_SR) || (nib == CTL_MOD) || (nib == CTL_RS) || (nib == CTL_RE);
   endfunction

   // trap has no register field; it works on the stack register
   function automatic dsc_reg_idx_t reg_field(input dsc_instr_t w);
      reg_field = (w[15:8] == OP_TRAP) ? STACK_REG : w[11:8];
   endfunction

   assign sys_sel = sys_src(ir_ff[7:4]);
   assign ctl_rd = ctl_src(ir_ff[7:4]);
   assign is_sts = ir_ff[15:12] == OPG_ZERO && ir_ff[3:0] == LO_STS && sys_sel[32];
   assign is_stc = ir_ff[15:12] == OPG_ZERO && ir_ff[3:0] == LO_STC && ctl_rd[32];
   assign is_sts_pd = ir_ff[15:12] == OPG_FOUR && ir_ff[3:0] == LO_STS_PD && sys_sel[32];
   assign is_stc_pd = ir_ff[15:12] == OPG_FOUR && ir_ff[3:0] == LO_STC_PD && ctl_rd[32];
   assign is_ldc = ir_ff[15:12] == OPG_FOUR && ir_ff[3:0] == LO_LDC && ctl_loadable(ir_ff[7:4]);
   assign is_ldc_pi = ir_ff[15:12] == OPG_FOUR && ir_ff[3:0] == LO_LDC_PI
                      && ctl_loadable(ir_ff[7:4]);
   assign is_set_repeat_count_r = ir_ff[15:12] == OPG_FOUR && ir_ff[7:0] == LO_SET_REPEAT_COUNT_REG;
   assign is_set_repeat_count_i = ir_ff[15:8] == OP_SET_REPEAT_COUNT_IMM;
   assign is_load_repeat_start_pcrel = ir_ff[15:8] == OP_LOAD_REPEAT_START_PCREL;
   assign is_load_repeat_end_pcrel = ir_ff[15:8] == OP_LOAD_REPEAT_END_PCREL;
   assign is_trap = ir_ff[15:8] == OP_TRAP;
   assign is_sleep = ir_ff == OP_SLEEP;

   assign accept = state_ff == ST_IDLE && instr_valid;
   assign stall_need = (ext_load_valid && ext_load_dest == instr_word[11:8])
                       || misalign_ff;
   assign gpr_raddr = (state_ff == ST_IDLE) ? reg_field(instr_word) : reg_field(ir_ff);
   assign span = re_ff - rs_ff;

   dsc_gpr_mem u_gpr (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .rd_addr(gpr_raddr),
      .rd_data(gpr_rdata),
      .wr_en(gpr_we),
      .wr_addr(gpr_waddr),
      .wr_data(gpr_wdata)
   );

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_ir = ir_ff;
      nxt_pc = pc_ff;
      nxt_sp = sp_ff;
      nxt_trap_ph = trap_ph_ff;
      nxt_misalign = misalign_ff;
      nxt_ready = ready_ff;
      nxt_done = 1'b0;
      nxt_mreq = mreq_ff;
      nxt_mwe = mwe_ff;
      nxt_maddr = maddr_ff;
      nxt_mwdata = mwdata_ff;
      nxt_pcl = 1'b0;
      nxt_pclv = pclv_ff;
      nxt_sleep = sleep_ff;
      nxt_status = status_ff;
      nxt_rs = rs_ff;
      nxt_re = re_ff;
      nxt_mod = mod_ff;
      nxt_cnt = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 4'h1;
      gpr_we = 1'b0;
      gpr_waddr = ir_ff[11:8];
      gpr_wdata = WORD_RST;
      ctl_we = 1'b0;
      ctl_sel = ir_ff[7:4];
      ctl_val = gpr_rdata;
      finish = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (instr_valid) begin
               nxt_ir = instr_word;
               nxt_pc = instr_pc;
               nxt_cnt = 4'h1;
               nxt_ready = 1'b0;
               nxt_misalign = 1'b0;
               nxt_state = stall_need ? ST_STALL : ST_EXEC;
            end
         end
         ST_STALL: begin
            nxt_state = ST_EXEC;
         end
         ST_EXEC: begin
            finish = 1'b1;
            if (is_sts) begin
               gpr_we = 1'b1;
               gpr_wdata = sys_sel[31:0];
            end else if (is_stc) begin
               gpr_we = 1'b1;
               gpr_wdata = ctl_rd[31:0];
            end else if (is_sts_pd || is_stc_pd) begin
               gpr_we = 1'b1;
               gpr_wdata = gpr_rdata - PREDEC_STEP;
               nxt_maddr = gpr_rdata - PREDEC_STEP;
               nxt_mwdata = is_sts_pd ? sys_sel[31:0] : ctl_rd[31:0];
               nxt_mwe = 1'b1;
               nxt_state = ST_MEM;
               finish = 1'b0;
            end else if (is_ldc) begin
               ctl_we = 1'b1;
            end else if (is_ldc_pi) begin
               gpr_we = 1'b1;
               gpr_wdata = gpr_rdata + POSTINC_STEP;
               nxt_maddr = gpr_rdata;
               nxt_mwe = 1'b0;
               nxt_state = ST_MEM;
               finish = 1'b0;
            end else if (is_set_repeat_count_r) begin
               nxt_status[RC_HI:RC_LO] = gpr_rdata[11:0];
            end else if (is_set_repeat_count_i) begin
               nxt_status[RC_IMM_HI:RC_LO] = ir_ff[7:0];
               nxt_status[RC_HI:RC_UP_LO] = 4'h0;
            end else if (is_load_repeat_start_pcrel || is_load_repeat_end_pcrel) begin
               ctl_we = 1'b1;
               ctl_sel = is_load_repeat_start_pcrel ? CTL_RS : CTL_RE;
               ctl_val = pc_ff + {{23{ir_ff[7]}}, ir_ff[7:0], 1'b0};
            end else if (is_trap) begin
               gpr_we = 1'b1;
               gpr_waddr = STACK_REG;
               gpr_wdata = gpr_rdata - PREDEC_STEP;
               nxt_sp = gpr_rdata - PREDEC_STEP;
               nxt_maddr = gpr_rdata - PREDEC_STEP;
               nxt_mwdata = status_ff;
               nxt_mwe = 1'b1;
               nxt_trap_ph = 2'h1;
               nxt_state = ST_MEM;
               finish = 1'b0;
            end else if (is_sleep) begin
               nxt_state = ST_SLEEP;
               finish = 1'b0;
            end
            if (is_set_repeat_count_r || is_set_repeat_count_i) begin
               // flags and count land in the same edge
               if (span == SPAN_ONE) begin
                  nxt_status[RF_HI:RF_LO] = RF_ONE;
               end else if (span == SPAN_TWO) begin
                  nxt_status[RF_HI:RF_LO] = RF_TWO;
               end else if (span == SPAN_THREE) begin
                  nxt_status[RF_HI:RF_LO] = RF_THREE;
               end else begin
                  nxt_status[RF_HI:RF_LO] = RF_MORE;
               end
            end
         end
         ST_MEM: begin
            if (mreq_ff && mem_ack) begin
               nxt_mreq = 1'b0;
               case (trap_ph_ff)
                  2'h1: begin
                     gpr_we = 1'b1;
                     gpr_waddr = STACK_REG;
                     gpr_wdata = sp_ff - PREDEC_STEP;
                     nxt_maddr = sp_ff - PREDEC_STEP;
                     nxt_mwdata = pc_ff + PC_STEP;
                     nxt_trap_ph = 2'h2;
                  end
                  2'h2: begin
                     nxt_maddr = vector_base + {22'h0, ir_ff[7:0], 2'h0};
                     nxt_mwe = 1'b0;
                     nxt_trap_ph = 2'h3;
                  end
                  2'h3: begin
                     nxt_pclv = mem_rdata;
                     nxt_trap_ph = 2'h0;
                     nxt_state = ST_TRAP_END;
                  end
                  default: begin
                     if (!mwe_ff) begin
                        ctl_we = 1'b1;
                        ctl_val = mem_rdata;
                     end
                     finish = 1'b1;
                  end
               endcase
            end else begin
               nxt_mreq = !fetch_busy;
            end
         end
         ST_TRAP_END: begin
            // counter pads the trap to its full length on a fast bus
            if (cnt_ff >= TRAP_CYC - 4'h1) begin
               nxt_pcl = 1'b1;
               finish = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (!sleep_ff) begin
               nxt_sleep = cnt_ff >= SLEEP_CYC - 4'h1;
            end else if (wake_req) begin
               nxt_sleep = 1'b0;
               finish = 1'b1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (ctl_we) begin
         case (ctl_sel)
            CTL_SR: nxt_status = ctl_val;
            CTL_MOD: nxt_mod = ctl_val;
            CTL_RS: nxt_rs = ctl_val;
            CTL_RE: nxt_re = ctl_val;
            default: nxt_mod = mod_ff;
         endcase
      end
      if (finish) begin
         nxt_state = ST_IDLE;
         nxt_ready = 1'b1;
         nxt_done = 1'b1;
      end
      // a misaligned branch in the accept cycle is kept, not lost
      if (branch_taken && branch_target[1]) begin
         nxt_misalign = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         ir_ff <= 16'h0000;
         pc_ff <= WORD_RST;
         sp_ff <= WORD_RST;
         cnt_ff <= 4'h0;
         trap_ph_ff <= 2'h0;
         misalign_ff <= 1'b0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
         mreq_ff <= 1'b0;
         mwe_ff <= 1'b0;
         maddr_ff <= WORD_RST;
         mwdata_ff <= WORD_RST;
         pcl_ff <= 1'b0;
         pclv_ff <= WORD_RST;
         sleep_ff <= 1'b0;
         status_ff <= STATUS_RST;
         rs_ff <= WORD_RST;
         re_ff <= WORD_RST;
         mod_ff <= WORD_RST;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         ir_ff <= nxt_ir;
         pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;
         cnt_ff <= nxt_cnt;
         trap_ph_ff <= nxt_trap_ph;
         misalign_ff <= nxt_misalign;
         ready_ff <= nxt_ready;
         done_ff <= nxt_done;
         mreq_ff <= nxt_mreq;
         mwe_ff <= nxt_mwe;
         maddr_ff <= nxt_maddr;
         mwdata_ff <= nxt_mwdata;
         pcl_ff <= nxt_pcl;
         pclv_ff <= nxt_pclv;
         sleep_ff <= nxt_sleep;
         status_ff <= nxt_status;
         rs_ff <= nxt_rs;
         re_ff <= nxt_re;
         mod_ff <= nxt_mod;
      end
   end

   assign instr_ready = ready_ff;
   assign instr_done = done_ff;
   assign mem_req = mreq_ff;
   assign mem_we = mwe_ff;
   assign mem_addr = maddr_ff;
   assign mem_wdata = mwdata_ff;
   assign pc_load = pcl_ff;
   assign pc_load_val = pclv_ff;
   assign sleep_enter = sleep_ff;
   assign status_word = status_ff;
   assign repeat_start_addr = rs_ff;
   assign repeat_end_addr = re_ff;
   assign modulo_addr_reg = mod_ff;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   sequence s_exec(logic c);
      state_ff == ST_EXEC && c;
   endsequence
   sequence s_take(logic c);
      accept && !stall_need && c;
   endsequence

   property p_sts_copy;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_exec(is_sts) |-> gpr_we && gpr_waddr == ir_ff[11:8] && gpr_wdata == sys_sel[31:0];
   endproperty
   a_sts_copy: assert property (p_sts_copy) else $error("store to Rn wrong");

   property p_predec;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_exec(is_sts_pd) |=> mwe_ff && maddr_ff == $past(gpr_rdata) - PREDEC_STEP;
   endproperty
   a_predec: assert property (p_predec) else $error("predecrement store wrong");

   property p_trap_len;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_take(instr_word[15:8] == OP_TRAP) |=> !pcl_ff [*7];
   endproperty
   a_trap_len: assert property (p_trap_len) else $error("trap shorter than 8");

   property p_fetch_stall;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      state_ff == ST_MEM && !mreq_ff && fetch_busy |=> !mreq_ff;
   endproperty
   a_fetch_stall: assert property (p_fetch_stall) else $error("no contention stall");

   property p_load_use;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      accept && ext_load_valid && ext_load_dest == instr_word[11:8] |=> state_ff == ST_STALL;
   endproperty
   a_load_use: assert property (p_load_use) else $error("load-use not stalled");

   property p_misalign;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      branch_taken && branch_target[1] && !accept ##1 accept |=> state_ff == ST_STALL;
   endproperty
   a_misalign: assert property (p_misalign) else $error("4n+2 target not stalled");

   property p_sleep;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_take(instr_word == OP_SLEEP) |=> !sleep_ff ##1 !sleep_ff ##1 sleep_ff;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry timing wrong");

   property p_set_repeat_count_imm;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_exec(is_set_repeat_count_i) |=> status_ff[RC_HI:RC_LO] == {4'h0, $past(ir_ff[7:0])}
         && status_ff[15:4] == $past(status_ff[15:4]);
   endproperty
   a_set_repeat_count_imm: assert property (p_set_repeat_count_imm) else $error("immediate count wrong");

   property p_set_repeat_count_reg;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_exec(is_set_repeat_count_r && span == SPAN_TWO) |=> status_ff[RC_HI:RC_LO] == $past(gpr_rdata[11:0])
         && status_ff[RF_HI:RF_LO] == RF_TWO;
   endproperty
   a_set_repeat_count_reg: assert property (p_set_repeat_count_reg) else $error("register count wrong");

   property p_pcrel;
      @(posedge sys_clk) disable iff (sys_rst || !clk_en)
      s_exec(is_load_repeat_start_pcrel) |=> rs_ff == $past(pc_ff) + {{23{$past(ir_ff[7])}}, $past(ir_ff[7:0]), 1'b0};
   endproperty
   a_pcrel: assert property (p_pcrel) else $error("repeat start address wrong");
endmodule

// file: dsc_mem_model.sv
`timescale 1ns/100ps
module dsc_mem_model (
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input dsc_pkg::dsc_word_t mem_addr,
   input dsc_pkg::dsc_word_t mem_wdata,
   output logic mem_ack,
   output dsc_pkg::dsc_word_t mem_rdata
);
   import dsc_pkg::*;
   // slow mode holds ack back so the waits get exercised
   logic [1:0] wt_ff = 2'h0;
   dsc_word_t mem [0:63];
   dsc_word_t la;
   dsc_word_t lw;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   always @(posedge sys_clk) begin
      mem_ack <= 1'b0;
      // read data only valid with ack, so it keeps moving otherwise
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (wt_ff != 2'h0) begin
            wt_ff <= wt_ff - 2'h1;
         end else begin
            mem_ack <= 1'b1;
            wt_ff <= {slow, slow};
            mem_rdata <= mem[mem_addr[7:2]];
            if (mem_we) begin
               mem[mem_addr[7:2]] <= mem_wdata;
               la <= mem_addr;
               lw <= mem_wdata;
            end
         end
      end
   end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import dsc_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, iv = 1'b0, elv = 1'b0, bt = 1'b0, slow = 1'b0;
   logic rdy, done, mem_req, mem_we, mem_ack;
   dsc_instr_t iw = 16'h0;
   dsc_word_t pc = 32'h0, bta = 32'h0, dv = 32'hF20, vb = 32'h40;
   dsc_word_t mem_addr, mem_wdata, mem_rdata, plv, sw, rs, re, md;
   logic fb = 1'b0, wk = 1'b0, se;
   int error_cnt = 0, num_checks = 0, n, n1, n2;
   logic [3:0] src [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
   logic [1:0] fl [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   initial forever #2 sys_clk = ~sys_clk;
   dsc_sys_ctrl dut_u (.sys_clk, .sys_rst, .clk_en(1'b1), .instr_valid(iv), .instr_word(iw),
      .instr_pc(pc), .instr_ready(rdy), .instr_done(done), .ext_load_valid(elv),
      .ext_load_dest(4'h3), .branch_taken(bt), .branch_target(bta), .fetch_busy(fb),
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .pc_load(),
      .pc_load_val(plv), .sleep_enter(se), .wake_req(wk), .status_word(sw),
      .repeat_start_addr(rs), .repeat_end_addr(re), .modulo_addr_reg(md),
      .multiply_acc_high(dv), .multiply_acc_low(dv + 32'h1), .procedure_return(dv + 32'h2),
      .dsp_status(dv + 32'h3), .accumulator_zero(dv + 32'h4), .x_input_zero(dv + 32'h5),
      .x_input_one(dv + 32'h6), .y_input_zero(dv + 32'h7), .y_input_one(dv + 32'h8),
      .global_base(dv + 32'h9), .vector_base(vb));
   dsc_mem_model mem_u (.sys_clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
      .mem_rdata);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one instruction; k counts edges from take to done
   task exe(input logic [15:0] w, output int k);
      iw <= w;
      iv <= 1'b1;
      @(posedge sys_clk);
      iv <= 1'b0;
      for (k = 1; k < 40; k++) begin
         @(posedge sys_clk);
         if (done === 1'b1) break;
      end
      if (k == 40) begin
         error_cnt++;
         end_of_test;
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk(rdy, 1'b1);
      for (int i = 0; i < 9; i++) begin
         exe({8'h03, src[i], 4'hA}, n1);
         exe({8'h43, src[i], 4'h2}, n);
         chk(mem_u.la, dv + i - 4);
         chk(mem_u.lw, dv + i);
      end
      // fetch holds the bus for a while, so the store must take longer
      fb <= 1'b1;
      fork
         exe(16'h4302, n2);
         begin
            repeat (6) @(posedge sys_clk);
            fb <= 1'b0;
         end
      join
      chk(n2 > n, 1'b1);
      elv <= 1'b1;
      exe(16'h030A, n);
      elv <= 1'b0;
      chk(n, n1 + 1);
      // target 4 must not stall, target 6 must
      for (int i = 0; i < 2; i++) begin
         bt <= 1'b1;
         bta <= 32'h4 + 2 * i;
         @(posedge sys_clk);
         bt <= 1'b0;
         exe(16'h030A, n);
         chk(n, n1 + i);
      end
      pc <= 32'h100;
      exe(16'h8C00, n);
      chk(rs, 32'h100);
      exe(16'h4314, n);
      chk(sw >> 16, 32'hF20);
      chk(sw & 32'hC, 32'h8);
      exe(16'h8E01, n);
      exe(16'h4314, n);
      chk(sw & 32'hC, 32'h4);
      for (int k = 0; k < 4; k++) begin
         exe({8'h8E, 6'h0, k[1:0]}, n);
         chk(re, 32'h100 + 2 * k);
         exe({8'h82, 6'h14, k[1:0]}, n);
         chk(sw, {8'h0, 6'h14, k[1:0], 12'h0, fl[k], 2'h0});
      end
      fork
         exe(16'h001B, n);
         begin
            repeat (2) @(posedge sys_clk);
            chk(se, 1'b0);
            repeat (2) @(posedge sys_clk);
            chk(se, 1'b1);
            wk <= 1'b1;
         end
      join
      wk <= 1'b0;
      exe(16'h0F0A, n);
      mem_u.mem[19] = 32'hABCD0;
      slow <= 1'b1;
      pc <= 32'h200;
      exe(16'hC303, n);
      chk(plv, 32'hABCD0);
      chk(mem_u.mem[7], 32'h530008);
      chk(mem_u.mem[6], 32'h202);
      chk(n >= 8, 1'b1);
      exe(16'h4F5E, n);
      chk(md, 32'hF18);
      end_of_test;
   end
endmodule
